// [conversion_run_bit_pkg.sv]
// Shared constants for the converter sequencing and power-fail compare block
package conversion_run_bit_pkg;
    // Register addresses on the plain register port
    localparam logic [2:0] ADDR_MODE     = 3'h0;
    localparam logic [2:0] ADDR_CHANNEL  = 3'h1;
    localparam logic [2:0] ADDR_RESULT   = 3'h2;
    localparam logic [2:0] ADDR_PF_MODE  = 3'h3;
    localparam logic [2:0] ADDR_PF_THRES = 3'h4;
    localparam logic [2:0] ADDR_STATUS   = 3'h5;

    // Mode register fields
    localparam int MODE_RUN_BIT  = 7;
    localparam int MODE_TSEL_HI  = 5;
    localparam int MODE_TSEL_LO  = 3;
    localparam int MODE_CPWR_BIT = 0;

    // Power-fail mode fields
    localparam int PFM_ENABLE_BIT = 7;
    localparam int PFM_BELOW_BIT  = 6;

    // Status register fields
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_SETTLED_BIT = 1;
    localparam int STAT_PF_BIT      = 2;

    // Reset values
    localparam logic [7:0] MODE_RST  = 8'h00;
    localparam logic [2:0] CHAN_RST  = 3'h0;
    localparam logic [7:0] PFM_RST   = 8'h00;
    localparam logic [7:0] PFT_RST   = 8'h00;
    localparam logic [9:0] RES_RST   = 10'h000;

    // Timing: comparator settling interval
    localparam int CLK_PERIOD_NS = 40;
    localparam int SETTLE_NS     = 14000;
    localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Conversion shape: sampling steps before the ten bit trials
    localparam int SAMPLE_STEPS = 2;
    localparam int RES_BITS     = 10;
    localparam int STEP_BASE    = 2;

    // Top-level sequencer states, Gray along idle, delay, convert
    typedef enum logic [1:0] {
        CONVERSION_RUN_BIT_IDLE  = 2'b00,
        CONVERSION_RUN_BIT_DELAY = 2'b01,
        CONVERSION_RUN_BIT_CONV  = 2'b11
    } conversion_run_bit_state_e;
endpackage : conversion_run_bit_pkg

// [conversion_run_bit_sar.sv]
// Successive-approximation engine: sampling then ten bit trials
`timescale 1ns/1ns
module conversion_run_bit_sar
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Control
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic [3:0] step_len,
    // Analog comparator
    input  wire logic       cmp_hi,
    // Results
    output logic      [9:0] dac_code,
    output logic      [9:0] result,
    output logic            done,
    output logic            busy
);
    logic [9:0] trial_q, trial_d;
    logic [3:0] step_q,  step_d;
    logic [3:0] cyc_q,   cyc_d;
    logic       busy_q,  busy_d;
    logic       done_q,  done_d;
    logic [3:0] bit_idx;

    // Next trial pattern and step bookkeeping
    always_comb
    begin
        trial_d = trial_q;
        step_d  = step_q;
        cyc_d   = cyc_q;
        busy_d  = busy_q;
        done_d  = 1'b0;
        bit_idx = 4'(conversion_run_bit_pkg::RES_BITS - 1) - (step_q - 4'(conversion_run_bit_pkg::SAMPLE_STEPS));
        if (abort)
        begin
            busy_d = 1'b0;
        end
        else if (start)
        begin
            busy_d  = 1'b1;
            step_d  = 4'h0;
            cyc_d   = 4'h0;
            trial_d = 10'h200;
        end
        else if (busy_q)
        begin
            if (cyc_q == step_len - 4'h1)
            begin
                cyc_d = 4'h0;
                if (step_q >= 4'(conversion_run_bit_pkg::SAMPLE_STEPS))
                begin
                    // Keep or drop the trial bit, then try the next one
                    trial_d[bit_idx] = cmp_hi;
                    if (bit_idx != 4'h0)
                        trial_d[bit_idx - 4'h1] = 1'b1;
                end
                if (step_q == 4'(conversion_run_bit_pkg::SAMPLE_STEPS + conversion_run_bit_pkg::RES_BITS - 1))
                begin
                    busy_d = 1'b0;
                    done_d = 1'b1;
                end
                else
                    step_d = step_q + 4'h1;
            end
            else
                cyc_d = cyc_q + 4'h1;
        end
    end

    // Register the engine state
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            trial_q <= 10'h000;
            step_q  <= 4'h0;
            cyc_q   <= 4'h0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end
        else
        begin
            trial_q <= trial_d;
            step_q  <= step_d;
            cyc_q   <= cyc_d;
            busy_q  <= busy_d;
            done_q  <= done_d;
        end
    end

    assign dac_code = trial_q;
    assign result   = trial_q;
    assign done     = done_q;
    assign busy     = busy_q;
endmodule : conversion_run_bit_sar

// [conversion_run_bit_top.sv]
// Converter sequencing, register file and power-fail compare
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module conversion_run_bit_top
#(
    parameter int START_DLY_CYC = 4
)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Register port
    input  wire logic [2:0] reg_addr,
    input  wire logic [9:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [9:0] reg_rdata,
    output logic            bus_wait,
    // System state
    input  wire logic       standby,
    // Analog front end
    input  wire logic       cmp_hi,
    output logic      [9:0] dac_code,
    output logic      [2:0] analog_input_sel,
    output logic            comparator_power,
    // Events
    output logic            conversion_done_irq,
    output logic            powerfail_alarm
);
    conversion_run_bit_pkg::conversion_run_bit_state_e state_q, state_d;
    logic [7:0] mode_q,   mode_d;
    logic [2:0] chan_q,   chan_d;
    logic [7:0] pfm_q,    pfm_d;
    logic [7:0] pft_q,    pft_d;
    logic [9:0] res_q,    res_d;
    logic [9:0] pend_q,   pend_d;
    logic       pendv_q,  pendv_d;
    logic [9:0] rdata_q,  rdata_d;
    logic       wait_q,   wait_d;
    logic       irq_q,    irq_d;
    logic       pf_q,     pf_d;
    logic [7:0] dly_q,    dly_d;
    logic [8:0] settle_q, settle_d;
    logic       sar_start, sar_abort, sar_done, sar_busy;
    logic [9:0] sar_res,  sar_dac;
    logic       wr_mode, wr_chan, rd_res, run_ok, new_val;
    logic [9:0] store_val;

    // Cycles per bit step from the time-select field
    function automatic logic [3:0] step_cycles(input logic [2:0] tsel);
        step_cycles = 4'(conversion_run_bit_pkg::STEP_BASE) + {1'b0, tsel};
    endfunction : step_cycles

    // Power-fail test on the upper eight result bits
    function automatic logic pf_hit(input logic [9:0] res, input logic [7:0] powerfail_mode_reg,
                                    input logic [7:0] powerfail_threshold_reg);
        if (powerfail_mode_reg[conversion_run_bit_pkg::PFM_BELOW_BIT])
            pf_hit = res[9:2] < powerfail_threshold_reg;
        else
            pf_hit = res[9:2] >= powerfail_threshold_reg;
    endfunction : pf_hit

    conversion_run_bit_sar u_sar
    (
        .clk      (clk),
        .arst_n   (arst_n),
        .start    (sar_start),
        .abort    (sar_abort),
        .step_len (step_cycles(mode_q[conversion_run_bit_pkg::MODE_TSEL_HI:conversion_run_bit_pkg::MODE_TSEL_LO])),
        .cmp_hi   (cmp_hi),
        .dac_code (sar_dac),
        .result   (sar_res),
        .done     (sar_done),
        .busy     (sar_busy)
    );

    // Register access decode
    always_comb
    begin
        wr_mode = reg_wr && (reg_addr == conversion_run_bit_pkg::ADDR_MODE);
        wr_chan = reg_wr && (reg_addr == conversion_run_bit_pkg::ADDR_CHANNEL);
        rd_res  = reg_rd && (reg_addr == conversion_run_bit_pkg::ADDR_RESULT);
    end

    // Register file, read data and wait indication
    always_comb
    begin
        mode_d = mode_q;
        chan_d = chan_q;
        pfm_d  = pfm_q;
        pft_d  = pft_q;
        if (wr_mode)
            mode_d = reg_wdata[7:0];
        if (wr_chan)
            chan_d = reg_wdata[2:0];
        if (reg_wr && reg_addr == conversion_run_bit_pkg::ADDR_PF_MODE)
            pfm_d = reg_wdata[7:0];
        if (reg_wr && reg_addr == conversion_run_bit_pkg::ADDR_PF_THRES)
            pft_d = reg_wdata[7:0];
        // Wait on channel, power-fail and mode writes or result read
        wait_d = (reg_wr && (reg_addr == conversion_run_bit_pkg::ADDR_CHANNEL ||
                             reg_addr == conversion_run_bit_pkg::ADDR_PF_MODE ||
                             reg_addr == conversion_run_bit_pkg::ADDR_PF_THRES ||
                             reg_addr == conversion_run_bit_pkg::ADDR_MODE))
                 || rd_res;
        rdata_d = 10'h000;
        if (reg_rd)
        begin
            case (reg_addr)
                conversion_run_bit_pkg::ADDR_MODE:     rdata_d = {2'b00, mode_q};
                conversion_run_bit_pkg::ADDR_CHANNEL:  rdata_d = {7'h00, chan_q};
                conversion_run_bit_pkg::ADDR_RESULT:   rdata_d = res_q;
                conversion_run_bit_pkg::ADDR_PF_MODE:  rdata_d = {2'b00, pfm_q};
                conversion_run_bit_pkg::ADDR_PF_THRES: rdata_d = {2'b00, pft_q};
                conversion_run_bit_pkg::ADDR_STATUS:
                begin
                    rdata_d[conversion_run_bit_pkg::STAT_BUSY_BIT]    = (state_q != conversion_run_bit_pkg::CONVERSION_RUN_BIT_IDLE);
                    rdata_d[conversion_run_bit_pkg::STAT_SETTLED_BIT] = (settle_q == 9'h000) &&
                                                          mode_q[conversion_run_bit_pkg::MODE_CPWR_BIT];
                    rdata_d[conversion_run_bit_pkg::STAT_PF_BIT]      = pf_q;
                end
                default:                 rdata_d = 10'h000;
            endcase
        end
    end

    // Comparator settling counter, restarted when power is switched on
    always_comb
    begin
        settle_d = settle_q;
        if (!mode_q[conversion_run_bit_pkg::MODE_CPWR_BIT])
            settle_d = 9'(conversion_run_bit_pkg::SETTLE_CYC);
        else if (settle_q != 9'h000)
            settle_d = settle_q - 9'h001;
    end

    // Conversion sequencer
    always_comb
    begin
        state_d   = state_q;
        dly_d     = dly_q;
        sar_start = 1'b0;
        sar_abort = 1'b0;
        run_ok    = mode_d[conversion_run_bit_pkg::MODE_RUN_BIT] && !standby;
        if (!run_ok)
        begin
            state_d   = conversion_run_bit_pkg::CONVERSION_RUN_BIT_IDLE;
            sar_abort = 1'b1;
        end
        else if (wr_mode || wr_chan || state_q == conversion_run_bit_pkg::CONVERSION_RUN_BIT_IDLE)
        begin
            // Fresh start pays the start delay first
            state_d   = conversion_run_bit_pkg::CONVERSION_RUN_BIT_DELAY;
            dly_d     = 8'(START_DLY_CYC);
            sar_abort = 1'b1;
        end
        else
        begin
            case (state_q)
                conversion_run_bit_pkg::CONVERSION_RUN_BIT_DELAY:
                begin
                    if (dly_q == 8'h00)
                    begin
                        state_d   = conversion_run_bit_pkg::CONVERSION_RUN_BIT_CONV;
                        sar_start = 1'b1;
                    end
                    else
                        dly_d = dly_q - 8'h01;
                end
                conversion_run_bit_pkg::CONVERSION_RUN_BIT_CONV:
                begin
                    // Back-to-back restart: restart to done is the set time plus one cycle
                    if (sar_done || !sar_busy)
                        sar_start = 1'b1;
                end
                default: state_d = conversion_run_bit_pkg::CONVERSION_RUN_BIT_IDLE;
            endcase
        end
    end

    // Result storage, collisions and completion events
    always_comb
    begin
        res_d     = res_q;
        pend_d    = pend_q;
        pendv_d   = 1'b0;
        irq_d     = 1'b0;
        pf_d      = pf_q;
        new_val   = 1'b0;
        store_val = sar_res;
        if (wr_mode || wr_chan)
            new_val = 1'b0;
        else if (sar_done && rd_res)
        begin
            pendv_d = 1'b1;
            pend_d  = sar_res;
        end
        else if (pendv_q)
        begin
            new_val   = 1'b1;
            store_val = pend_q;
        end
        else if (sar_done)
            new_val = 1'b1;
        if (new_val)
        begin
            res_d = store_val;
            // Power-fail mode raises the event only on a compare hit
            if (pfm_q[conversion_run_bit_pkg::PFM_ENABLE_BIT])
            begin
                pf_d  = pf_hit(store_val, pfm_q, pft_q);
                irq_d = pf_d;
            end
            else
                irq_d = 1'b1;
        end
        if (!pfm_q[conversion_run_bit_pkg::PFM_ENABLE_BIT])
            pf_d = 1'b0;
    end

    // State registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q  <= conversion_run_bit_pkg::CONVERSION_RUN_BIT_IDLE;
            mode_q   <= conversion_run_bit_pkg::MODE_RST;
            chan_q   <= conversion_run_bit_pkg::CHAN_RST;
            pfm_q    <= conversion_run_bit_pkg::PFM_RST;
            pft_q    <= conversion_run_bit_pkg::PFT_RST;
            res_q    <= conversion_run_bit_pkg::RES_RST;
            pend_q   <= conversion_run_bit_pkg::RES_RST;
            pendv_q  <= 1'b0;
            rdata_q  <= 10'h000;
            wait_q   <= 1'b0;
            irq_q    <= 1'b0;
            pf_q     <= 1'b0;
            dly_q    <= 8'h00;
            settle_q <= 9'(conversion_run_bit_pkg::SETTLE_CYC);
        end
        else
        begin
            state_q  <= state_d;
            mode_q   <= mode_d;
            chan_q   <= chan_d;
            pfm_q    <= pfm_d;
            pft_q    <= pft_d;
            res_q    <= res_d;
            pend_q   <= pend_d;
            pendv_q  <= pendv_d;
            rdata_q  <= rdata_d;
            wait_q   <= wait_d;
            irq_q    <= irq_d;
            pf_q     <= pf_d;
            dly_q    <= dly_d;
            settle_q <= settle_d;
        end
    end

    // Outputs straight from flops
    assign reg_rdata           = rdata_q;
    assign bus_wait            = wait_q;
    assign dac_code            = sar_dac;
    assign analog_input_sel    = chan_q;
    assign comparator_power    = mode_q[conversion_run_bit_pkg::MODE_CPWR_BIT];
    assign conversion_done_irq = irq_q;
    assign powerfail_alarm     = pf_q;
endmodule : conversion_run_bit_top

// [conversion_run_bit_checker.sv]
// Assertion checker for the converter control block
`timescale 1ns/1ns
module conversion_run_bit_checker
#(
    parameter int START_DLY_CYC = 4
)
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       arst_n,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [9:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [9:0] reg_rdata,
    input wire logic       bus_wait,
    // System and analog side
    input wire logic       standby,
    input wire logic       cmp_hi,
    input wire logic [9:0] dac_code,
    input wire logic [2:0] analog_input_sel,
    input wire logic       comparator_power,
    // Events
    input wire logic       conversion_done_irq,
    input wire logic       powerfail_alarm
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // Access decode
    logic wait_acc;
    logic cfg_wr;
    logic res_rd;
    assign cfg_wr = reg_wr && (reg_addr == conversion_run_bit_pkg::ADDR_MODE
                    || reg_addr == conversion_run_bit_pkg::ADDR_CHANNEL);
    assign res_rd = reg_rd && reg_addr == conversion_run_bit_pkg::ADDR_RESULT;
    assign wait_acc = cfg_wr || res_rd || reg_wr && (reg_addr == conversion_run_bit_pkg::ADDR_PF_MODE
                      || reg_addr == conversion_run_bit_pkg::ADDR_PF_THRES);

    a_wait_on_access: assert property (wait_acc |=> bus_wait)
        else $error("bus wait missing after access");
    a_wait_only_access: assert property (!wait_acc |=> !bus_wait)
        else $error("bus wait without access");
    a_cfg_write_drop: assert property (cfg_wr |=> !conversion_done_irq [*8])
        else $error("interrupt after mode or channel write");
    a_standby_quiet: assert property (standby [*2] |=> !conversion_done_irq)
        else $error("interrupt during standby");
    a_irq_single: assert property (conversion_done_irq |=> !conversion_done_irq [*8])
        else $error("interrupt not a single pulse");
    a_read_wins: assert property (
        res_rd ##1 (res_rd && !conversion_done_irq)
        |=> reg_rdata == $past(reg_rdata))
        else $error("result changed under a colliding read");
    // A lone result read never lets a store land on the next edge
    a_read_first: assert property (
        res_rd && !$past(res_rd) |=> !conversion_done_irq)
        else $error("store landed under a result read");
    a_sel_follows: assert property (
        reg_wr && reg_addr == conversion_run_bit_pkg::ADDR_CHANNEL
        |=> analog_input_sel == $past(reg_wdata[2:0]))
        else $error("channel select not taken");
    a_power_follows: assert property (
        reg_wr && reg_addr == conversion_run_bit_pkg::ADDR_MODE
        |=> comparator_power == $past(reg_wdata[0]))
        else $error("comparator power not taken");
endmodule : conversion_run_bit_checker

bind conversion_run_bit_top conversion_run_bit_checker #(.START_DLY_CYC(START_DLY_CYC)) u_chk (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_wait(bus_wait),
    .standby(standby), .cmp_hi(cmp_hi), .dac_code(dac_code),
    .analog_input_sel(analog_input_sel), .comparator_power(comparator_power),
    .conversion_done_irq(conversion_done_irq), .powerfail_alarm(powerfail_alarm));

// [conversion_run_bit_sequencing_and_powerfail_compare_tb.sv]
// Self-checking testbench for the converter control block
`timescale 1ns/1ns
module conversion_run_bit_sequencing_and_powerfail_compare_tb;
    // Stimulus and observed signals
    logic       clk;
    logic       arst_n;
    logic [2:0] reg_addr;
    logic [9:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [9:0] reg_rdata;
    logic       bus_wait;
    logic       standby;
    logic       cmp_hi;
    logic [9:0] dac_code;
    logic [2:0] analog_input_sel;
    logic       comparator_power;
    logic       conversion_done_irq;
    logic       powerfail_alarm;
    logic [9:0] ain [8];
    int         fail_count;
    int         check_count;

    conversion_run_bit_top #(.START_DLY_CYC(4)) u_dut (
        .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_wait(bus_wait),
        .standby(standby), .cmp_hi(cmp_hi), .dac_code(dac_code),
        .analog_input_sel(analog_input_sel), .comparator_power(comparator_power),
        .conversion_done_irq(conversion_done_irq), .powerfail_alarm(powerfail_alarm));

    // Analog source: comparator sees the selected input
    assign cmp_hi = (ain[analog_input_sel] >= dac_code);

    // Clock, 40 ns period; never a subsystem-only phase
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Compare and count
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One-cycle register write, wait flag sampled after
    task automatic wr(input logic [2:0] a, input logic [9:0] d, output logic w);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
        w = bus_wait;
    endtask : wr

    // One-cycle register read
    task automatic rd(input logic [2:0] a, output logic [9:0] d, output logic w);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
        w = bus_wait;
    endtask : rd

    // Two reads back to back
    task automatic rd2(input logic [2:0] a, output logic [9:0] d1, output logic [9:0] d2);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        repeat (2) @(posedge clk);
        reg_rd <= 1'b0;
        d1 = reg_rdata;
        @(posedge clk);
        d2 = reg_rdata;
    endtask : rd2

    // Edges until the next interrupt, bounded
    task automatic wait_irq(output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (conversion_done_irq !== 1'b1 && n < 1000);
        if (n >= 1000)
            check("irq timeout", 10'h000, 10'h001);
    endtask : wait_irq

    // Interrupts seen over a span
    task automatic count_irq(input int cyc, output int k);
        k = 0;
        repeat (cyc)
        begin
            @(posedge clk);
            k += int'(conversion_done_irq === 1'b1);
        end
    endtask : count_irq

    task automatic tdone(input string s);
        $display("test %s finished", s);
    endtask : tdone

    // Counts and verdict
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // Watchdog
    initial
    begin
        repeat (40000) @(posedge clk);
        fail_count++;
        final_report();
    end

    // Main sequence
    initial
    begin
        logic       w;
        logic [9:0] d;
        logic [9:0] d1;
        logic [9:0] d2;
        int         n;
        int         n0;
        arst_n    = 1'b0;
        reg_addr  = 3'h0;
        reg_wdata = 10'h000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        standby   = 1'b0;
        for (int i = 0; i < 8; i++)
            ain[i] = 10'h05a + 10'(i * 113);
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        // Reset values and wait cycles across the whole map
        for (int a = 0; a < 8; a++)
        begin
            wr(3'(a), 10'h000, w);
            check("write wait", {9'h0, w}, {9'h0, a inside {0, 1, 3, 4}});
            rd(3'(a), d, w);
            check("read wait", {9'h0, w}, {9'h0, a == 2});
            check("reset value", d, 10'h000);
        end
        wr(conversion_run_bit_pkg::ADDR_PF_THRES, 10'h0a5, w);
        rd(conversion_run_bit_pkg::ADDR_PF_THRES, d, w);
        check("threshold", d, 10'h0a5);
        tdone("map");
        // Comparator power first, then the settling interval before any run
        wr(conversion_run_bit_pkg::ADDR_MODE, 10'(1 << conversion_run_bit_pkg::MODE_CPWR_BIT), w);
        rd(conversion_run_bit_pkg::ADDR_STATUS, d, w);
        check("not settled", d, 10'h000);
        repeat (conversion_run_bit_pkg::SETTLE_CYC) @(posedge clk);
        rd(conversion_run_bit_pkg::ADDR_STATUS, d, w);
        check("settled", d, 10'(1 << conversion_run_bit_pkg::STAT_SETTLED_BIT));
        tdone("power-up");
        // Every conversion time code, channel and mode rewritten while running
        for (int t = 0; t < 8; t++)
        begin
            wr(conversion_run_bit_pkg::ADDR_CHANNEL, 10'(t), w);
            wr(conversion_run_bit_pkg::ADDR_MODE, 10'h081 | 10'(t << 3), w);
            wait_irq(n0);
            wait_irq(n);
            // Restart to done is the set time, plus the restart cycle
            check("period", 10'(n), 10'(12 * (2 + t) + 1));
            check("start longer", 10'(n0 > n), 10'h001);
            rd(conversion_run_bit_pkg::ADDR_RESULT, d, w);
            check("result", d, ain[t]);
        end
        tdone("timing");
        // Result read colliding with the end of conversion
        wait_irq(n);
        d = ain[7];
        ain[7] <= 10'h2c3;
        // Second read meets the end of conversion
        repeat (12 * 9 - 2) @(posedge clk);
        rd2(conversion_run_bit_pkg::ADDR_RESULT, d1, d2);
        check("first read", d1, d);
        check("colliding read", d2, d);
        wait_irq(n);
        check("late store", 10'(n), 10'h001);
        rd(conversion_run_bit_pkg::ADDR_RESULT, d, w);
        check("stored after", d, 10'h2c3);
        tdone("collision");
        // Standby halts conversion
        standby <= 1'b1;
        count_irq(324, n);
        check("standby irq", 10'(n), 10'h000);
        standby <= 1'b0;
        wait_irq(n);
        tdone("standby");
        // Power-fail compare: hit, then miss
        wr(conversion_run_bit_pkg::ADDR_PF_THRES, 10'h080, w);
        wr(conversion_run_bit_pkg::ADDR_PF_MODE, 10'h080, w);
        ain[7] <= 10'h3ff;
        wait_irq(n);
        wait_irq(n);
        check("pf period", 10'(n), 10'(12 * 9 + 1));
        check("alarm on", {9'h0, powerfail_alarm}, 10'h001);
        rd(conversion_run_bit_pkg::ADDR_STATUS, d, w);
        check("status run", d, 10'((1 << conversion_run_bit_pkg::STAT_BUSY_BIT) +
                                   (1 << conversion_run_bit_pkg::STAT_SETTLED_BIT) +
                                   (1 << conversion_run_bit_pkg::STAT_PF_BIT)));
        ain[7] <= 10'h100;
        count_irq(324, n);
        check("miss irq", 10'(n), 10'h000);
        check("alarm off", {9'h0, powerfail_alarm}, 10'h000);
        wr(conversion_run_bit_pkg::ADDR_PF_MODE, 10'h000, w);
        tdone("powerfail");
        // Run and power cleared: conversions stop, comparator off
        wr(conversion_run_bit_pkg::ADDR_MODE, 10'h000, w);
        count_irq(216, n);
        check("stopped irq", 10'(n), 10'h000);
        check("power off", {9'h0, comparator_power}, 10'h000);
        rd(conversion_run_bit_pkg::ADDR_STATUS, d, w);
        check("status idle", d, 10'h000);
        tdone("stop");
        final_report();
    end
endmodule : conversion_run_bit_sequencing_and_powerfail_compare_tb
